// File: include/mrr_defs.vh
// Constants of the holding-register read/write query handler.
// Assumes a byte-level serial receiver and transmitter on the same clock.
// Notes on behaviour
// - Reads reach every holding register class
// - Read query: addr, func, start, count, check
// - First register is start field plus 40001
// - Read query to address zero is ignored
// - At most 125 registers per read
// - Read reply: addr, func, twice-count, data, check
// - Words high byte first, ascending addresses
// - Writes only to environment and parameter registers
// - Write query: addr, func, register, data, check
// - Write target is register field plus 40001
// - Write to address zero is broadcast, performed
// - Write data is always two bytes
// - Addressed write answered by echo of query
// - Never reply to a broadcast
// - Check appended low byte, then high
// - Error reply carries function plus 80 hex
// - Recompute check; mismatch marks frame bad
`ifndef MRR_DEFS_VH
`define MRR_DEFS_VH

// Function codes and address values
`define MRR_FN_READ 8'h03
`define MRR_FN_WRITE 8'h06
`define MRR_FN_ERR 8'h80
`define MRR_BCAST 8'h00

// Holding register numbering
`define MRR_HREG_BASE 17'h09c41
`define MRR_MAX_REGS 16'h007d

// Frame lengths in bytes
`define MRR_QUERY_LEN 4'h8
`define MRR_MIN_LEN 4'h4

// Exception codes of error replies
`define MRR_EXC_FUNC 8'h01
`define MRR_EXC_ADDR 8'h02
`define MRR_EXC_VALUE 8'h03

// Check value arithmetic
`define MRR_CRC_INIT 16'hffff
`define MRR_CRC_POLY 16'ha001
`define MRR_CRC_GOOD 16'h0000

// Register classes reported by the register store
`define MRR_CLS_ENV 2'h0
`define MRR_CLS_MON 2'h1
`define MRR_CLS_FAULT 2'h2
`define MRR_CLS_PARAM 2'h3

`endif

// File: rtl/mrr_crc16.v
// Running 16-bit frame check over a byte stream.
// Assumes clr and en are never needed in the same cycle; clr wins.
`include "mrr_defs.vh"

module mrr_crc16 (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Byte stream
	input wire clr,
	input wire en,
	input wire [7:0] din,
	// Result
	output reg [15:0] crc_q
);

	reg [15:0] crc_d;
	integer i;

	always @* begin
		crc_d = crc_q ^ {8'h00, din};
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_d[0]) begin
				crc_d = (crc_d >> 1) ^ `MRR_CRC_POLY;
			end else begin
				crc_d = crc_d >> 1;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			crc_q <= `MRR_CRC_INIT;
		end else if (clr) begin
			crc_q <= `MRR_CRC_INIT;
		end else if (en) begin
			crc_q <= crc_d;
		end
	end

endmodule // mrr_crc16

// File: rtl/mrr_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data are held in flip-flops.

module mrr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					mem_q[g] <= {WIDTH{1'b0}};
				end else if (push &&
					{{(32-AW){1'b0}}, wr_ptr_q} == g) begin
					mem_q[g] <= in_data;
				end
			end
		end
	endgenerate

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule // mrr_fifo

// File: rtl/mrr_top.v
// Query handler for holding-register read and single-register write.
// Assumes an upstream byte receiver that marks frame end by silence
// (RX_END one or more cycles after the last byte) and a register store
// that classifies REG_ADDR combinationally and answers reads later.
`include "mrr_defs.vh"

module mrr_top #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
) (
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Configuration
	input wire [7:0] SLAVE_ADDR,
	// Received bytes
	input wire RX_VALID,
	input wire [7:0] RX_DATA,
	input wire RX_END,
	// Reply bytes
	output wire TX_VALID,
	output wire [7:0] TX_DATA,
	input wire TX_READY,
	// Holding register store
	output reg [16:0] REG_ADDR,
	output reg REG_RD,
	input wire [15:0] REG_RDATA,
	input wire REG_RVALID,
	input wire [1:0] REG_CLASS,
	output reg REG_WR,
	output reg [15:0] REG_WDATA,
	// Status
	output wire BUSY
);

	////////////////////////////////////////////////////////////////////
	// States

	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_DEC = 4'h1;
	localparam [3:0] S_WCHK = 4'h2;
	localparam [3:0] S_HDR = 4'h3;
	localparam [3:0] S_RDREQ = 4'h4;
	localparam [3:0] S_RDWAIT = 4'h5;
	localparam [3:0] S_DHI = 4'h6;
	localparam [3:0] S_DLO = 4'h7;
	localparam [3:0] S_CRCL = 4'h8;
	localparam [3:0] S_CRCH = 4'h9;

	reg [3:0] state_q;
	reg [3:0] after_hdr_q;

	////////////////////////////////////////////////////////////////////
	// Received frame

	reg [63:0] frame_q;
	reg [3:0] rx_cnt_q;
	reg [7:0] rx_addr_q;
	reg [7:0] rx_func_q;
	wire [15:0] rx_crc;
	wire rx_take;
	wire rx_clr;

	// Bytes are only taken while idle; a query during a reply is lost
	assign rx_take = (state_q == S_IDLE) && RX_VALID;
	assign rx_clr = (state_q == S_DEC);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			frame_q <= 64'h0000000000000000;
			rx_cnt_q <= 4'h0;
			rx_addr_q <= 8'h00;
			rx_func_q <= 8'h00;
		end else if (rx_clr) begin
			rx_cnt_q <= 4'h0;
		end else if (rx_take) begin
			frame_q <= {frame_q[55:0], RX_DATA};
			// Saturate above the query length so long frames fail
			if (rx_cnt_q != `MRR_QUERY_LEN + 4'h1) begin
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			if (rx_cnt_q == 4'h0) begin
				rx_addr_q <= RX_DATA;
			end
			if (rx_cnt_q == 4'h1) begin
				rx_func_q <= RX_DATA;
			end
		end
	end

	wire clk_w;
	assign clk_w = CLK;

	// Running check includes the trailing check bytes, so a good frame
	// leaves the register at zero
	mrr_crc16 u_rx_crc (
		.clk(clk_w),
		.rst(SYS_RST),
		.clr(rx_clr),
		.en(rx_take),
		.din(RX_DATA),
		.crc_q(rx_crc)
	);

	// Field views of an eight-byte query, high byte first
	wire [15:0] fld_addr;
	wire [15:0] fld_data;
	assign fld_addr = frame_q[47:32];
	assign fld_data = frame_q[31:16];

	wire frame_ok;
	wire frame_len8;
	wire is_bcast;
	wire is_mine;
	assign frame_ok = (rx_cnt_q >= `MRR_MIN_LEN) &&
		(rx_crc == `MRR_CRC_GOOD);
	assign frame_len8 = (rx_cnt_q == `MRR_QUERY_LEN);
	assign is_bcast = (rx_addr_q == `MRR_BCAST);
	assign is_mine = (rx_addr_q == SLAVE_ADDR) && !is_bcast;

	////////////////////////////////////////////////////////////////////
	// Reply path

	reg [47:0] out_q;
	reg [2:0] out_len_q;
	reg [15:0] remain_q;
	reg [15:0] rdata_q;
	reg bcast_q;
	reg [7:0] push_data;
	wire push_valid;
	wire push_ready;
	wire push_take;
	wire [15:0] tx_crc;
	wire tx_crc_en;

	assign push_valid = (state_q == S_HDR) || (state_q == S_DHI) ||
		(state_q == S_DLO) || (state_q == S_CRCL) ||
		(state_q == S_CRCH);
	assign push_take = push_valid && push_ready;
	assign tx_crc_en = push_take && (state_q != S_CRCL) &&
		(state_q != S_CRCH);

	always @* begin
		case (state_q)
			S_HDR: push_data = out_q[47:40];
			S_DHI: push_data = rdata_q[15:8];
			S_DLO: push_data = rdata_q[7:0];
			S_CRCL: push_data = tx_crc[7:0];
			S_CRCH: push_data = tx_crc[15:8];
			default: push_data = 8'h00;
		endcase
	end

	mrr_crc16 u_tx_crc (
		.clk(CLK),
		.rst(SYS_RST),
		.clr(rx_clr),
		.en(tx_crc_en),
		.din(push_data),
		.crc_q(tx_crc)
	);

	// Stalls in the reply path hold the sequencer in its state
	mrr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(CLK),
		.rst(SYS_RST),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(TX_VALID),
		.out_ready(TX_READY),
		.out_data(TX_DATA)
	);

	assign BUSY = (state_q != S_IDLE);

	////////////////////////////////////////////////////////////////////
	// Sequencer

	wire cls_writable;
	assign cls_writable = (REG_CLASS == `MRR_CLS_ENV) ||
		(REG_CLASS == `MRR_CLS_PARAM);

	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q <= S_IDLE;
			after_hdr_q <= S_CRCL;
			out_q <= 48'h000000000000;
			out_len_q <= 3'h0;
			remain_q <= 16'h0000;
			rdata_q <= 16'h0000;
			bcast_q <= 1'b0;
			REG_ADDR <= 17'h00000;
			REG_RD <= 1'b0;
			REG_WR <= 1'b0;
			REG_WDATA <= 16'h0000;
		end else begin
			REG_RD <= 1'b0;
			REG_WR <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (RX_END) begin
						state_q <= S_DEC;
					end
				end
				S_DEC: begin
					bcast_q <= is_bcast;
					state_q <= S_IDLE;
					after_hdr_q <= S_CRCL;
					if (frame_ok && (is_mine || is_bcast)) begin
						if (rx_func_q == `MRR_FN_READ) begin
							if (is_bcast || !frame_len8) begin
								state_q <= S_IDLE;
							end else if (fld_data == 16'h0000 ||
								fld_data > `MRR_MAX_REGS) begin
								out_q <= {rx_addr_q,
									rx_func_q | `MRR_FN_ERR,
									`MRR_EXC_VALUE, 24'h000000};
								out_len_q <= 3'h3;
								state_q <= S_HDR;
							end else begin
								REG_ADDR <= {1'b0, fld_addr} +
									`MRR_HREG_BASE;
								remain_q <= fld_data;
								out_q <= {rx_addr_q, `MRR_FN_READ,
									fld_data[6:0], 1'b0,
									24'h000000};
								out_len_q <= 3'h3;
								after_hdr_q <= S_RDREQ;
								state_q <= S_HDR;
							end
						end else if (rx_func_q == `MRR_FN_WRITE) begin
							if (frame_len8) begin
								REG_ADDR <= {1'b0, fld_addr} +
									`MRR_HREG_BASE;
								REG_WDATA <= fld_data;
								state_q <= S_WCHK;
							end
						end else if (!is_bcast) begin
							out_q <= {rx_addr_q,
								rx_func_q | `MRR_FN_ERR,
								`MRR_EXC_FUNC, 24'h000000};
							out_len_q <= 3'h3;
							state_q <= S_HDR;
						end
					end
				end
				S_WCHK: begin
					// Class is looked up from REG_ADDR set last cycle
					if (cls_writable) begin
						REG_WR <= 1'b1;
						if (bcast_q) begin
							state_q <= S_IDLE;
						end else begin
							out_q <= frame_q[63:16];
							out_len_q <= 3'h6;
							state_q <= S_HDR;
						end
					end else if (bcast_q) begin
						state_q <= S_IDLE;
					end else begin
						out_q <= {rx_addr_q,
							rx_func_q | `MRR_FN_ERR,
							`MRR_EXC_ADDR, 24'h000000};
						out_len_q <= 3'h3;
						state_q <= S_HDR;
					end
				end
				S_HDR: begin
					if (push_take) begin
						out_q <= {out_q[39:0], 8'h00};
						out_len_q <= out_len_q - 3'h1;
						if (out_len_q == 3'h1) begin
							state_q <= after_hdr_q;
						end
					end
				end
				S_RDREQ: begin
					REG_RD <= 1'b1;
					state_q <= S_RDWAIT;
				end
				S_RDWAIT: begin
					if (REG_RVALID) begin
						rdata_q <= REG_RDATA;
						state_q <= S_DHI;
					end
				end
				S_DHI: begin
					if (push_take) begin
						state_q <= S_DLO;
					end
				end
				S_DLO: begin
					if (push_take) begin
						remain_q <= remain_q - 16'h0001;
						REG_ADDR <= REG_ADDR + 17'h00001;
						if (remain_q == 16'h0001) begin
							state_q <= S_CRCL;
						end else begin
							state_q <= S_RDREQ;
						end
					end
				end
				S_CRCL: begin
					if (push_take) begin
						state_q <= S_CRCH;
					end
				end
				S_CRCH: begin
					if (push_take) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

endmodule // mrr_top

// File: dv/mrr_chk_chk.sv
// Checker on the query handler's top-level ports.
// Assumes one clock domain; bound onto every mrr_top.
module mrr_chk (
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Reply side
	input wire TX_VALID,
	input wire [7:0] TX_DATA,
	input wire TX_READY,
	// Store side and busy status
	input wire [16:0] REG_ADDR,
	input wire REG_RD,
	input wire [1:0] REG_CLASS,
	input wire REG_WR,
	input wire BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	reg seen_q;
	reg [16:0] last_q;
	reg [11:0] busy_cyc_q;
	// A full 125-word read at slowest store latency outruns 1000 cycles
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST)
			busy_cyc_q <= 12'h000;
		else if (!BUSY)
			busy_cyc_q <= 12'h000;
		else if (busy_cyc_q != 12'hfff)
			busy_cyc_q <= busy_cyc_q + 12'h001;
	end
	always @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			seen_q <= 1'b0;
			last_q <= 17'h0;
		end else if (!BUSY) begin
			seen_q <= 1'b0;
		end else if (REG_RD) begin
			seen_q <= 1'b1;
			last_q <= REG_ADDR;
		end
	end
	////////////////////////////////////////////////////////////////////
	sequence s_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence s_done;
		##[1:1000] !BUSY;
	endsequence
	a_tx_hold: assert property (s_stall |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte moved while stalled");
	a_rd_step: assert property (REG_RD && seen_q |-> REG_ADDR == last_q + 17'h1)
		else $error("read address not ascending");
	a_rd_base: assert property (REG_RD |-> REG_ADDR >= 17'h09c41)
		else $error("read below register base");
	a_wr_base: assert property (REG_WR |-> REG_ADDR >= 17'h09c41)
		else $error("write below register base");
	a_wr_class: assert property (REG_WR |-> REG_CLASS == 2'h0 || REG_CLASS == 2'h3)
		else $error("write to read-only class");
	a_wr_pulse: assert property (REG_WR |=> !REG_WR)
		else $error("write pulse too long");
	a_idle_quiet: assert property (!BUSY |-> !REG_RD)
		else $error("read while idle");
	a_busy_end: assert property (busy_cyc_q < 12'hbb8)
		else $error("reply never finished");
	a_wr_done: assert property (REG_WR |-> s_done)
		else $error("write handling never finished");
endmodule // mrr_chk
bind mrr_top mrr_chk mrr_chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
	.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
	.REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_CLASS(REG_CLASS),
	.REG_WR(REG_WR), .BUSY(BUSY));

// File: dv/mrr_store.sv
// Holding register store behind the handler.
// Assumes the bench picks the read latency; class is address low bits.
module mrr_store (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Store port
	input wire [16:0] addr,
	input wire rd,
	output reg [15:0] rdata,
	output reg rvalid,
	output wire [1:0] cls,
	input wire wr,
	input wire [15:0] wdata,
	// Bench view
	input wire [1:0] lat,
	output reg [7:0] wr_cnt,
	output reg [31:0] wr_log
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [2:0] cnt_q;
	assign cls = addr[1:0];
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
			rvalid <= 1'b0;
			rdata <= 16'h0;
			wr_cnt <= 8'h0;
			wr_log <= 32'h0;
		end else begin
			rvalid <= 1'b0;
			// Stale data wanders so it is never mistaken for an answer
			rdata <= ~rdata;
			if (rd)
				cnt_q <= {1'b0, lat} + 3'h1;
			else if (cnt_q != 3'h0)
				cnt_q <= cnt_q - 3'h1;
			if (!rd && cnt_q == 3'h1) begin
				rvalid <= 1'b1;
				rdata <= addr[15:0] ^ 16'h5a5a;
			end
			if (wr) begin
				wr_cnt <= wr_cnt + 8'h1;
				wr_log <= {addr[15:0], wdata};
			end
		end
	end
endmodule // mrr_store

// File: dv/tb_top.sv
// Self-checking bench for the query handler.
// Assumes mrr_store as register store; bench is master and reply sink.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [7:0] own = 8'h11;
	reg clk, rst, rx_v, rx_e, tx_r;
	reg [7:0] rx_d;
	reg [1:0] lat;
	reg [15:0] ec;
	reg [31:0] rnd;
	wire tx_v, rd, rv, wr, busy;
	wire [7:0] tx_d, wcnt;
	wire [15:0] rdat, wdat;
	wire [16:0] radr;
	wire [1:0] cls;
	wire [31:0] wlog;
	integer err_total, n_tests, cyc, k;
	reg [7:0] exp_q[$];
	mrr_top #(.FIFO_DEPTH(4), .FIFO_AW(2)) mrr_top_i (.CLK(clk),
		.SYS_RST(rst), .SLAVE_ADDR(own), .RX_VALID(rx_v), .RX_DATA(rx_d),
		.RX_END(rx_e), .TX_VALID(tx_v), .TX_DATA(tx_d), .TX_READY(tx_r),
		.REG_ADDR(radr), .REG_RD(rd), .REG_RDATA(rdat), .REG_RVALID(rv),
		.REG_CLASS(cls), .REG_WR(wr), .REG_WDATA(wdat), .BUSY(busy));
	mrr_store mrr_store_i (.clk(clk), .rst(rst), .addr(radr), .rd(rd),
		.rdata(rdat), .rvalid(rv), .cls(cls), .wr(wr), .wdata(wdat),
		.lat(lat), .wr_cnt(wcnt), .wr_log(wlog));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] want);
		begin
			n_tests = n_tests + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
			end
		end
	endtask
	task summarize;
		begin
			$display("errors=%0d checks=%0d", err_total, n_tests);
			if (err_total == 0 && n_tests > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	function [15:0] cup(input [15:0] c, input [7:0] d);
		integer b;
		begin
			cup = c ^ {8'h0, d};
			for (b = 0; b < 8; b++)
				cup = cup[0] ? (cup >> 1) ^ 16'ha001 : cup >> 1;
		end
	endfunction
	task ex(input [7:0] d);
		begin
			exp_q.push_back(d);
			ec = cup(ec, d);
		end
	endtask
	task exend;
		begin
			exp_q.push_back(ec[7:0]);
			exp_q.push_back(ec[15:8]);
		end
	endtask
	task rep_err(input [7:0] a, input [7:0] f, input [7:0] code);
		begin
			ex(a);
			ex(f | 8'h80);
			ex(code);
			exend;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// Reply sink stalls at random to fill the reply buffer
	always @(negedge clk)
		tx_r <= ($urandom & 32'h3) != 32'h0;
	always @(posedge clk) begin
		if ((tx_v & tx_r & ~rst) === 1'b1) begin
			if (exp_q.size() == 0)
				chk({24'h0, tx_d}, 32'h1ff);
			else
				chk({24'h0, tx_d}, {24'h0, exp_q.pop_front()});
		end
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			summarize;
		end
	end
	////////////////////////////////////////////////////////////////////
	task send(input [7:0] a, input [7:0] f, input [15:0] x,
		input [15:0] y, input bad);
		reg [7:0] b[0:7];
		reg [15:0] c;
		integer i;
		begin
			b[0] = a;
			b[1] = f;
			b[2] = x[15:8];
			b[3] = x[7:0];
			b[4] = y[15:8];
			b[5] = y[7:0];
			c = 16'hffff;
			for (i = 0; i < 6; i++)
				c = cup(c, b[i]);
			b[6] = c[7:0] ^ {7'h0, bad};
			b[7] = c[15:8];
			for (i = 0; i < 8; i++) begin
				@(negedge clk);
				rx_v = 1'b1;
				rx_d = b[i];
			end
			@(negedge clk);
			rx_v = 1'b0;
			rx_d = ~rx_d;
			@(negedge clk);
			rx_e = 1'b1;
			@(negedge clk);
			rx_e = 1'b0;
		end
	endtask
	task run(input [7:0] a, input [7:0] f, input [15:0] x,
		input [15:0] y, input bad);
		reg [16:0] r;
		reg [15:0] v;
		reg [7:0] n0;
		reg we;
		integer i;
		begin
			ec = 16'hffff;
			we = 1'b0;
			n0 = wcnt;
			rnd = $urandom;
			lat = rnd[1:0];
			r = {1'b0, x} + 17'h09c41;
			if (bad || (a != own && a != 8'h0) || (a == 8'h0 && f != 8'h06)) begin
				// Dropped without reply
			end else if (f != 8'h03 && f != 8'h06) begin
				rep_err(a, f, 8'h01);
			end else if (f == 8'h03 && (y == 16'h0 || y > 16'd125)) begin
				rep_err(a, f, 8'h03);
			end else if (f == 8'h03) begin
				ex(a);
				ex(f);
				ex({y[6:0], 1'b0});
				for (i = 0; i < y; i++) begin
					v = (r[15:0] + i[15:0]) ^ 16'h5a5a;
					ex(v[15:8]);
					ex(v[7:0]);
				end
				exend;
			end else if (r[1] != r[0]) begin
				if (a != 8'h0)
					rep_err(a, f, 8'h02);
			end else begin
				we = 1'b1;
				if (a != 8'h0) begin
					ex(a);
					ex(f);
					ex(x[15:8]);
					ex(x[7:0]);
					ex(y[15:8]);
					ex(y[7:0]);
					exend;
				end
			end
			send(a, f, x, y, bad);
			i = 0;
			while ((busy !== 1'b0 || exp_q.size() != 0) && i < 3000) begin
				@(negedge clk);
				i++;
			end
			repeat (8) @(negedge clk);
			chk(32'(exp_q.size()), 32'h0);
			chk({24'h0, wcnt}, {24'h0, n0 + {7'h0, we}});
			if (we)
				chk(wlog, {r[15:0], y});
			exp_q.delete();
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		rx_v = 1'b0;
		rx_e = 1'b0;
		rx_d = 8'h0;
		tx_r = 1'b0;
		lat = 2'h0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		rnd = $urandom(32'hd714);
		repeat (8) @(negedge clk);
		rst = 1'b0;
		run(own, 8'h03, 16'h03eb, 16'h0003, 1'b0);
		run(own, 8'h03, rnd[15:0], 16'd125, 1'b0);
		run(own, 8'h03, 16'h0000, 16'h0000, 1'b0);
		run(own, 8'h03, 16'h0001, 16'd126, 1'b0);
		run(8'h00, 8'h03, 16'h0001, 16'h0001, 1'b0);
		run(8'h5a, 8'h03, 16'h0001, 16'h0001, 1'b0);
		run(own, 8'h03, 16'h0001, 16'h0001, 1'b1);
		for (k = 0; k < 8; k++) begin
			rnd = $urandom;
			run(k[2] ? 8'h00 : own, 8'h06, 16'h000c + k[1:0], rnd[31:16],
				1'b0);
		end
		run(own, 8'h08, 16'h0000, 16'h1234, 1'b0);
		run(own, 8'h10, 16'h0001, 16'h0001, 1'b0);
		run(8'h00, 8'h08, 16'h0000, 16'h1234, 1'b0);
		summarize;
	end
endmodule // tb_top
